// ### logic/system_control_reset_sleep_regs.sv
// Our own choices: the Wishbone register port and the register offsets.
`include "sysctl_regs.svh"
// How it works
// - Control-word writes without unlock key are discarded; low-power writes need no key
// - Upper half reads key status pattern
// - Byte-order flag bit 15 reads zero
// - Three-bit priority split field, read-write
// - Split value n: subpriority bits n..0
// - Preemption compares group portion only
// - Keyed one pulses reset request; reads zero
// - Debug bits read zero, writes ignored
// - Clear: only enabled interrupts wake
// - Set: any pending interrupt also wakes
// - Pending event wakes or latches for wait
// - Send-event or external event ends wait
// - Deep-sleep bit chooses sleep or deep
// - Sleep-on-exit sleeps on handler return
module system_control_reset_sleep_regs #(
  parameter int PRIO_BITS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire sysctl_pkg::wb_req_t wb_req,
  output sysctl_pkg::wb_rsp_t wb_rsp,
  // Priority comparison for preemption
  input wire logic [7:0] active_priority,
  input wire logic [7:0] pending_priority,
  output logic preempt,
  // Wake sources from the core
  input wire logic irq_pending_rise,
  input wire logic irq_rise_enabled,
  input wire logic event_in,
  input wire logic send_event_instruction,
  input wire logic wait_for_event_instruction,
  input wire logic wfi_instruction,
  input wire logic handler_return_to_thread,
  // Power management side
  output logic system_reset_request,
  output logic sleep_req,
  output logic deep_sleep_req,
  output logic waiting_event,
  output logic wake
);
  import sysctl_pkg::*;

  // Ports and mask are 8 bits wide; other widths are not served
  if (PRIO_BITS != 8)
  begin : g_prio_check
    $error("PRIO_BITS must be 8");
  end

  logic [2:0] priority_split_select;
  logic wake_on_any_pending;
  logic deep_sleep_select;
  logic sleep_after_handler_return;
  logic event_latch;
  logic ack_q;
  power_state_t state;
  power_state_t next_state;
  logic req;
  logic wr_app;
  logic wr_lp;
  logic [PRIO_BITS-1:0] group_mask;
  logic [7:0] group_pend;
  logic [7:0] group_act;
  logic [31:0] rd_word;
  logic [31:0] rsp_dat;
  logic key_ok;
  logic pend_event;
  logic wake_event;
  logic sleep_entry;

  // Single-cycle request, one ack per access
  assign req = wb_req.cyc && wb_req.stb && !ack_q;
  // Key sits in the upper half; both upper lanes must carry it
  assign key_ok = wb_req.sel[3] && wb_req.sel[2]
    && wb_req.dat[`KEY_HI:`KEY_LO] == `WRITE_UNLOCK_KEY;
  // Unkeyed writes are still acked, just not applied
  assign wr_app = req && wb_req.we && wb_req.adr == `OFS_APP_IRC && key_ok;
  assign wr_lp = req && wb_req.we && wb_req.adr == `OFS_LOW_POWER && wb_req.sel[0];

  // Ack register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
    end
  end

  // Read mux; reserved, write-only and unmapped positions read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (wb_req.adr)
      `OFS_APP_IRC:
      begin
        rd_word[`KEY_HI:`KEY_LO] = `KEY_STATUS_READBACK;
        rd_word[`BIT_ENDIAN] = 1'b0;
        rd_word[`SPLIT_HI:`SPLIT_LO] = priority_split_select;
        rd_word[`BIT_RESET_REQ] = 1'b0;
        rd_word[`BIT_DBG_CLR_ACTIVE] = 1'b0;
        rd_word[`BIT_DBG_LOCAL_RESET] = 1'b0;
      end
      `OFS_LOW_POWER:
      begin
        rd_word[`BIT_WAKE_ANY_PEND] = wake_on_any_pending;
        rd_word[`BIT_DEEP_SLEEP] = deep_sleep_select;
        rd_word[`BIT_SLEEP_AFTER_RET] = sleep_after_handler_return;
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data register, loaded on every take so it stands with ack
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rsp_dat <= 32'h0000_0000;
    end
    else if (req)
    begin
      rsp_dat <= rd_word;
    end
  end

  // One driver for the whole answer struct
  assign wb_rsp = '{ack: ack_q, dat: rsp_dat};

  // Priority split field
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      priority_split_select <= `SPLIT_RESET;
    end
    else if (wr_app && wb_req.sel[1])
    begin
      priority_split_select <= wb_req.dat[`SPLIT_HI:`SPLIT_LO];
    end
  end

  // Reset request pulse; debug bits are not acted on
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      system_reset_request <= 1'b0;
    end
    else
    begin
      // Writing zero leaves nothing pending; outer system handles debug exemption
      system_reset_request <= wr_app && wb_req.sel[0] && wb_req.dat[`BIT_RESET_REQ];
    end
  end

  // Low-power control bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {wake_on_any_pending, deep_sleep_select, sleep_after_handler_return} <= `LOW_POWER_RESET;
    end
    else if (wr_lp)
    begin
      wake_on_any_pending <= wb_req.dat[`BIT_WAKE_ANY_PEND];
      deep_sleep_select <= wb_req.dat[`BIT_DEEP_SLEEP];
      sleep_after_handler_return <= wb_req.dat[`BIT_SLEEP_AFTER_RET];
    end
  end

  // Group mask: bits above n form the group
  genvar gi;
  generate
    for (gi = 0; gi < PRIO_BITS; gi++)
    begin : g_mask
      assign group_mask[gi] = (3'(gi) > priority_split_select) && (gi != 0);
    end
  endgenerate

  // Subpriority bits masked off before the compare
  assign group_pend = pending_priority & group_mask;
  assign group_act = active_priority & group_mask;

  // Lower group value preempts; equal groups never do
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      preempt <= 1'b0;
    end
    else
    begin
      preempt <= group_pend < group_act;
    end
  end

  // Which pending edges count as wake events
  assign pend_event = wake_on_any_pending ? irq_pending_rise : irq_rise_enabled;
  assign wake_event = pend_event || event_in || send_event_instruction;
  // Sleep on wait-for-interrupt, or on handler return when armed
  assign sleep_entry = wfi_instruction || (handler_return_to_thread && sleep_after_handler_return);

  // Event latch: set wins over the consume by a wait
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      event_latch <= 1'b0;
    end
    else if (wake_event && state != st_wait)
    begin
      event_latch <= 1'b1;
    end
    else if (wait_for_event_instruction && state == st_run)
    begin
      // A wait that finds the latch set consumes it
      event_latch <= 1'b0;
    end
  end

  // Power state selection
  always_comb
  begin
    next_state = state;
    case (state)
      st_run:
      begin
        // An event in this very cycle ends the wait before it starts
        if (wait_for_event_instruction && !event_latch && !wake_event)
        begin
          next_state = st_wait;
        end
        else if (sleep_entry)
        begin
          next_state = deep_sleep_select ? st_deep : st_sleep;
        end
      end
      st_wait:
      begin
        // Pending edge, send-event or external event
        if (wake_event)
        begin
          next_state = st_run;
        end
      end
      st_sleep, st_deep:
      begin
        // Send-event alone does not end a sleep
        if (pend_event || event_in)
        begin
          next_state = st_run;
        end
      end
      default:
      begin
        next_state = st_run;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= st_run;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Wake pulse on any return to run, one cycle long
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wake <= 1'b0;
    end
    else
    begin
      wake <= (state != st_run) && (next_state == st_run);
    end
  end

  assign sleep_req = (state == st_sleep);
  assign deep_sleep_req = (state == st_deep);
  assign waiting_event = (state == st_wait);

endmodule

// ### pkg/sysctl_regs.svh
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

// Register byte offsets
`define OFS_APP_IRC 8'h00
`define OFS_LOW_POWER 8'h04

// Key handling
`define KEY_HI 31
`define KEY_LO 16
`define WRITE_UNLOCK_KEY 16'h05fa
`define KEY_STATUS_READBACK 16'hfa05

// Application interrupt and reset control fields
`define BIT_ENDIAN 15
`define SPLIT_HI 10
`define SPLIT_LO 8
`define BIT_RESET_REQ 2
`define BIT_DBG_CLR_ACTIVE 1
`define BIT_DBG_LOCAL_RESET 0
`define SPLIT_RESET 3'h0

// Low-power control fields
`define BIT_WAKE_ANY_PEND 4
`define BIT_DEEP_SLEEP 2
`define BIT_SLEEP_AFTER_RET 1
`define LOW_POWER_RESET 3'h0

`endif

// ### pkg/sysctl_pkg.sv
package sysctl_pkg;

  // Wishbone request from master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone answer from slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Core power state
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_deep = 2'b10,
    st_wait = 2'b11
  } power_state_t;

endpackage

// ### test/sysctl_sva.sv
module sysctl_sva (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic reset,
  input wire sysctl_pkg::wb_req_t wb_req,
  input wire sysctl_pkg::wb_rsp_t wb_rsp,
  // Core and power side
  input wire logic [7:0] active_priority,
  input wire logic [7:0] pending_priority,
  input wire logic preempt,
  input wire logic irq_pending_rise,
  input wire logic irq_rise_enabled,
  input wire logic event_in,
  input wire logic send_event_instruction,
  input wire logic handler_return_to_thread,
  input wire logic system_reset_request,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic waiting_event,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 1ps;
  import sysctl_pkg::*;
  logic [4:0] lp;
  logic tk;
  logic run;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Request taken, core running
  assign tk = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  assign run = !sleep_req && !deep_sleep_req && !waiting_event;
  // Shadow of the low-power bits, so the sleep checks know the mode
  always_ff @(posedge clk)
  begin
    if (reset)
      lp <= 5'h00;
    else if (tk && wb_req.we && wb_req.adr == 8'h04 && wb_req.sel[0])
      lp <= wb_req.dat[4:0];
  end
  a_take_acked: assert property (tk |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus take not acked once");
  a_key_status: assert property (tk && !wb_req.we && wb_req.adr == 8'h00 |=>
    wb_rsp.dat[31:11] == {16'hfa05, 5'h00} && wb_rsp.dat[7:0] == 8'h00)
    else $error("control word readback wrong");
  a_lp_readback: assert property (tk && !wb_req.we && wb_req.adr == 8'h04 |=>
    wb_rsp.dat == {27'h0, lp[4], 1'b0, lp[2:1], 1'b0}) else $error("low-power readback wrong");
  a_reset_keyed: assert property (system_reset_request |-> $past(tk && wb_req.we &&
    wb_req.adr == 8'h00 && wb_req.dat[31:16] == 16'h05fa && wb_req.dat[2]))
    else $error("reset request without keyed write");
  a_no_preempt: assert property (pending_priority >= active_priority |=> !preempt)
    else $error("preempt with no higher group");
  a_exit_sleep: assert property (run && handler_return_to_thread && lp[1] |=>
    (sleep_req || deep_sleep_req) && deep_sleep_req == lp[2]) else $error("no sleep on exit");
  a_exit_plain: assert property (run && handler_return_to_thread && !lp[1] |=> run)
    else $error("slept on plain return");
  a_pend_wake: assert property (waiting_event && lp[4] && irq_pending_rise |=>
    wake && !waiting_event) else $error("pending irq did not wake");
  a_masked_pend: assert property (waiting_event && !lp[4] && irq_pending_rise
    && !irq_rise_enabled && !send_event_instruction && !event_in |=> waiting_event)
    else $error("disabled pending irq woke the core");
  a_event_wake: assert property (waiting_event && (send_event_instruction || event_in)
    |=> wake) else $error("event did not end wait");
endmodule

bind system_control_reset_sleep_regs sysctl_sva u_sva (.clk, .reset, .wb_req, .wb_rsp,
  .active_priority, .pending_priority, .preempt, .irq_pending_rise, .irq_rise_enabled,
  .event_in, .send_event_instruction, .handler_return_to_thread, .system_reset_request,
  .sleep_req, .deep_sleep_req, .waiting_event, .wake);

// ### test/power_mgr_model.sv
module power_mgr_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // From the block; lag of zero never wakes
  input wire logic system_reset_request,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [3:0] lag,
  // Wake event and tallies
  output logic event_in,
  output int resets,
  output int deeps
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Outer reset only counted: debug logic stays out of its reach
  always_ff @(posedge clk)
  begin
    if (reset)
      resets <= 0;
    else if (system_reset_request)
      resets <= resets + 1;
  end
  // Wake a sleeping core after lag cycles, counting deep entries
  always_ff @(posedge clk)
  begin
    event_in <= 1'b0;
    if (reset)
      deeps <= 0;
    if (reset || !(sleep_req || deep_sleep_req))
      cnt <= 0;
    else
    begin
      cnt <= cnt + 1;
      if (deep_sleep_req && cnt == 0)
        deeps <= deeps + 1;
      if (lag != 4'h0 && cnt == int'(lag))
        event_in <= 1'b1;
    end
  end
endmodule

// ### test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sysctl_pkg::*;
  localparam int pnd = 0, ena = 1, snd = 2, wte = 3, wfi = 4, ret = 5;
  logic clk, reset, pre, ev, srr, slp, dslp, wev, wk;
  wb_req_t rq;
  wb_rsp_t rs;
  logic [7:0] ap, pp;
  logic [5:0] pv;
  logic [3:0] lag;
  int err_total, num_checks, resets, deeps, tick, split, lp;
  system_control_reset_sleep_regs dut (.clk, .reset, .wb_req(rq), .wb_rsp(rs),
    .active_priority(ap), .pending_priority(pp), .preempt(pre), .irq_pending_rise(pv[0]),
    .irq_rise_enabled(pv[1]), .event_in(ev), .send_event_instruction(pv[2]),
    .wait_for_event_instruction(pv[3]), .wfi_instruction(pv[4]),
    .handler_return_to_thread(pv[5]), .system_reset_request(srr), .sleep_req(slp),
    .deep_sleep_req(dslp), .waiting_event(wev), .wake(wk));
  power_mgr_model pm (.clk, .reset, .system_reset_request(srr), .sleep_req(slp),
    .deep_sleep_req(dslp), .lag, .event_in(ev), .resets, .deeps);
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    rq <= '{1'b1, 1'b1, w, a, 4'hf, d};
    // Ends once ack is seen; the hang guard catches an ack that never comes
    do
      @(posedge clk);
    while (rs.ack !== 1'b1);
    chk(rs.ack, 1);
    q = rs.dat;
    rq <= '0;
    @(posedge clk);
    chk(rs.ack, 0);
  endtask
  task automatic pulse(input int k);
    pv <= 6'(1 << k);
    @(posedge clk);
    pv <= '0;
    @(posedge clk);
  endtask
  // Reference readback from the bench's own register copy
  function automatic logic [31:0] exp_rd(input int a);
    if (a == 0)
      return {16'hfa05, 5'h00, 3'(split), 8'h00};
    return a == 4 ? 32'(lp) : 32'h0;
  endfunction
  // Free-running clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    tick++;
    if (tick == 5000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    logic [31:0] q;
    int a, p, g;
    {reset, rq, ap, pp, pv, lag} = '1;
    {rq, ap, pp, pv, lag, err_total, num_checks, tick, split, lp} = '0;
    a = $urandom(48);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (a = 0; a < 12; a += 4)
    begin
      wb(0, 8'(a), 0, q);
      chk(q, exp_rd(a));
    end
    // Every split value, reserved bits written with junk
    for (int n = 0; n < 8; n++)
    begin
      wb(1, 0, {16'h05fa, 1'b1, 4'($urandom), 3'(n), 5'($urandom), 3'h0}, q);
      split = n;
      wb(0, 0, 0, q);
      chk(q, exp_rd(0));
      repeat (4)
      begin
        a = $urandom & 255;
        p = $urandom & 255;
        ap <= 8'(a);
        pp <= 8'(p);
        g = 'hff << (n + 1);
        repeat (2) @(posedge clk);
        chk(pre, (p & g & 255) < (a & g & 255));
      end
    end
    wb(1, 0, {16'h05f9, 16'h0504}, q);
    wb(0, 0, 0, q);
    chk(q, exp_rd(0));
    wb(1, 0, {16'h05fa, 16'h0004}, q);
    split = 0;
    wb(1, 0, {16'h05fa, 16'h0000}, q);
    wb(0, 0, 0, q);
    chk(q, exp_rd(0));
    chk(resets, 1);
    // Sleep then deep sleep, far side slow the second time
    for (int d = 0; d < 2; d++)
    begin
      lp = 2 + 4 * d;
      lag <= 4'(1 + 6 * d);
      wb(1, 4, ($urandom & 32'hffffffe9) | lp, q);
      wb(0, 4, 0, q);
      chk(q, exp_rd(4));
      pulse(d ? wfi : ret);
      chk({dslp, slp}, d ? 2 : 1);
      repeat (20)
      begin
        @(posedge clk);
        if (wk === 1'b1)
          break;
      end
      chk(wk, 1);
    end
    chk(deeps, 1);
    lp = 0;
    wb(1, 4, 0, q);
    pulse(ret);
    chk({dslp, slp, wev}, 0);
    pulse(snd);
    pulse(wte);
    chk(wev, 0);
    pulse(wte);
    chk(wev, 1);
    pulse(pnd);
    chk(wev, 1);
    pulse(ena);
    chk(wk, 1);
    lp = 16;
    wb(1, 4, 16, q);
    pulse(wte);
    pulse(pnd);
    chk(wk, 1);
    pulse(wte);
    pulse(snd);
    chk(wk, 1);
    // Mid-run reset puts both registers back to zero
    wb(1, 0, {16'h05fa, 16'h0500}, q);
    split = 5;
    wb(0, 0, 0, q);
    chk(q, exp_rd(0));
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    split = 0;
    lp = 0;
    wb(0, 0, 0, q);
    chk(q, exp_rd(0));
    wb(0, 4, 0, q);
    chk(q, exp_rd(4));
    summarize();
  end
endmodule
